/* File: dcache_pkg.sv */
// Operation
// - bit 0 of population register flags a fitted 4-MB local memory.
// - page policy bit 4: 0 keeps rows open, 1 closes them.
// - override bit 3 forces activate-to-command delay to 2 clocks.
// - latency bit 2 picks column latency and default delay: 2 or 3.
// - row timing bit 1: 5/8 clocks when 0, 10 clocks when 1.
// - precharge bit 0 picks row precharge time of 2 or 3 clocks.
// - refresh field 4:3: 00 off, 01 normal, others reserved.
// - command mode 000 gives ordinary reads and writes.
// - command mode 001 turns local memory cycles into no-operations.
// - command mode 010 turns local memory cycles into precharge-all.
// - command mode 011 turns cycles into mode register set commands.
// - mode set carries address bits 6:0; bits 11:7 driven zero.
// - command mode 100 gives refresh cycles; 101 and 11x reserved.
// - registers reached only through memory space at base plus offset.
package dcache_pkg;
  localparam logic [15:0] POP_OFS = 16'h3000;
  localparam logic [15:0] TIM_OFS = 16'h3001;
  localparam logic [15:0] CMD_OFS = 16'h3002;
  localparam logic [7:0] POP_RST = 8'h00;
  localparam logic [7:0] TIM_RST = 8'h17;
  localparam logic [7:0] CMD_RST = 8'h08;
  localparam logic [7:0] POP_MASK = 8'h01;
  localparam logic [7:0] TIM_MASK = 8'h1f;
  localparam logic [7:0] CMD_MASK = 8'h1f;
  localparam int FIT_BIT = 0;
  localparam int PAGE_BIT = 4;
  localparam int RCO_BIT = 3;
  localparam int LAT_BIT = 2;
  localparam int RAS_BIT = 1;
  localparam int PRE_BIT = 0;
  localparam int RFR_LO = 3;
  localparam int MODE_LO = 0;
  localparam logic [3:0] RCD_FORCED = 4'h2;
  localparam logic [3:0] LAT_SHORT = 4'h2;
  localparam logic [3:0] LAT_LONG = 4'h3;
  localparam logic [3:0] RAS_SHORT = 4'h5;
  localparam logic [3:0] RC_SHORT = 4'h8;
  localparam logic [3:0] RAS_LONG = 4'ha;
  localparam logic [3:0] RC_LONG = 4'ha;
  localparam logic [3:0] RP_SHORT = 4'h2;
  localparam logic [3:0] RP_LONG = 4'h3;
  localparam logic [1:0] RFR_OFF = 2'h0;
  localparam logic [1:0] RFR_NORMAL = 2'h1;
  localparam logic [2:0] normal_mode_code = 3'h0;
  localparam logic [2:0] nop_force_code = 3'h1;
  localparam logic [2:0] precharge_all_force_code = 3'h2;
  localparam logic [2:0] mode_set_force_code = 3'h3;
  localparam logic [2:0] refresh_cycle_force_code = 3'h4;
  typedef enum logic [2:0] {
    CMD_NONE, CMD_ACCESS, CMD_NOP, CMD_PRE_ALL, CMD_MODE_SET, CMD_REFRESH
  } sdram_cmd_t;
endpackage

/* File: dcache_cmd_force.sv */
`timescale 1ns/10ps
`default_nettype none
module dcache_cmd_force (
  // mode and request
  input wire logic [2:0] command_mode_field_in,
  input wire logic mem_cycle_in,
  input wire logic [11:0] addr_in,
  // resulting command
  output dcache_pkg::sdram_cmd_t cmd_out,
  output logic [11:0] addr_out
);
  import dcache_pkg::*;
  always_comb begin
    cmd_out = CMD_NONE;
    addr_out = addr_in;
    if (mem_cycle_in) begin
      unique case (command_mode_field_in)
        normal_mode_code: cmd_out = CMD_ACCESS;
        nop_force_code: cmd_out = CMD_NOP;
        precharge_all_force_code: cmd_out = CMD_PRE_ALL;
        mode_set_force_code: begin
          cmd_out = CMD_MODE_SET;
          addr_out = {5'h00, addr_in[6:0]};
        end
        refresh_cycle_force_code: cmd_out = CMD_REFRESH;
        // reserved codes issue nothing rather than guess
        default: cmd_out = CMD_NONE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: dcache_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
module dcache_ctrl (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  // memory-space register port, offset already relative to base
  input wire logic reg_sel_in,
  input wire logic reg_wr_in,
  input wire logic [15:0] reg_ofs_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // memory cycle request
  input wire logic mem_cycle_in,
  input wire logic [11:0] mem_addr_in,
  // sdram command and timing
  output dcache_pkg::sdram_cmd_t sdram_cmd_out,
  output logic [11:0] local_memory_address_lines_out,
  output logic memory_fitted_flag_out,
  output logic page_policy_select_out,
  output logic [3:0] rcd_clocks_out,
  output logic [3:0] cas_clocks_out,
  output logic [3:0] ras_clocks_out,
  output logic [3:0] rc_clocks_out,
  output logic [3:0] rp_clocks_out,
  output logic refresh_enable_out
);
  import dcache_pkg::*;

  // offset decode shared by the write and read paths
  function automatic logic [1:0] reg_slot(input logic [15:0] ofs);
    logic [1:0] slot;
    slot = 2'h0;
    if (ofs == POP_OFS) slot = 2'h1;
    if (ofs == TIM_OFS) slot = 2'h2;
    if (ofs == CMD_OFS) slot = 2'h3;
    return slot;
  endfunction

  typedef struct packed {
    logic [7:0] local_memory_population;
    logic [7:0] sdram_timing_control;
    logic [7:0] refresh_and_command_control;
    logic [7:0] rdata;
    sdram_cmd_t cmd;
    logic [11:0] addr;
    logic [3:0] rcd;
    logic [3:0] cas;
    logic [3:0] ras;
    logic [3:0] rc;
    logic [3:0] rp;
    logic rfr;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  sdram_cmd_t fcmd;
  logic [11:0] faddr;

  ////////////////////////////////////////////////////////////////////
  dcache_cmd_force u_force (
    .command_mode_field_in(st_r.refresh_and_command_control[MODE_LO +: 3]),
    .mem_cycle_in(mem_cycle_in),
    .addr_in(mem_addr_in),
    .cmd_out(fcmd),
    .addr_out(faddr)
  );

  ////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    // only the three memory offsets decode; no io alias exists
    if (reg_sel_in && reg_wr_in) begin
      unique case (reg_slot(reg_ofs_in))
        2'h1: st_nxt.local_memory_population = reg_wdata_in & POP_MASK;
        2'h2: st_nxt.sdram_timing_control = reg_wdata_in & TIM_MASK;
        2'h3: st_nxt.refresh_and_command_control = reg_wdata_in & CMD_MASK;
        default: ;
      endcase
    end
    st_nxt.rdata = 8'h00;
    if (reg_sel_in && !reg_wr_in) begin
      unique case (reg_slot(reg_ofs_in))
        2'h1: st_nxt.rdata = st_r.local_memory_population;
        2'h2: st_nxt.rdata = st_r.sdram_timing_control;
        2'h3: st_nxt.rdata = st_r.refresh_and_command_control;
        default: st_nxt.rdata = 8'h00;
      endcase
    end
    st_nxt.cmd = fcmd;
    st_nxt.addr = faddr;
    st_nxt.cas = st_r.sdram_timing_control[LAT_BIT] ? LAT_LONG : LAT_SHORT;
    st_nxt.rcd = st_r.sdram_timing_control[RCO_BIT] ? RCD_FORCED : st_nxt.cas;
    st_nxt.ras = st_r.sdram_timing_control[RAS_BIT] ? RAS_LONG : RAS_SHORT;
    st_nxt.rc = st_r.sdram_timing_control[RAS_BIT] ? RC_LONG : RC_SHORT;
    st_nxt.rp = st_r.sdram_timing_control[PRE_BIT] ? RP_LONG : RP_SHORT;
    // reserved refresh codes treated as off to avoid odd rates
    st_nxt.rfr = (st_r.refresh_and_command_control[RFR_LO +: 2] == RFR_NORMAL);
  end

  ////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_r.local_memory_population <= POP_RST;
      st_r.sdram_timing_control <= TIM_RST;
      st_r.refresh_and_command_control <= CMD_RST;
      st_r.rdata <= 8'h00;
      st_r.cmd <= CMD_NONE;
      st_r.addr <= 12'h000;
      st_r.rcd <= LAT_LONG;
      st_r.cas <= LAT_LONG;
      st_r.ras <= RAS_LONG;
      st_r.rc <= RC_LONG;
      st_r.rp <= RP_LONG;
      st_r.rfr <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata_out = st_r.rdata;
  assign sdram_cmd_out = st_r.cmd;
  assign local_memory_address_lines_out = st_r.addr;
  assign memory_fitted_flag_out = st_r.local_memory_population[FIT_BIT];
  assign page_policy_select_out = st_r.sdram_timing_control[PAGE_BIT];
  assign rcd_clocks_out = st_r.rcd;
  assign cas_clocks_out = st_r.cas;
  assign ras_clocks_out = st_r.ras;
  assign rc_clocks_out = st_r.rc;
  assign rp_clocks_out = st_r.rp;
  assign refresh_enable_out = st_r.rfr;
endmodule
`default_nettype wire

/* File: dcache_ctrl_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module dcache_ctrl_chk
  import dcache_pkg::*;
(
  input wire logic core_clk_in, rst_in, reg_sel_in, reg_wr_in, mem_cycle_in,
  input wire logic [15:0] reg_ofs_in,
  input wire logic [7:0] reg_wdata_in, reg_rdata_out,
  input wire logic [11:0] mem_addr_in, local_memory_address_lines_out,
  input wire sdram_cmd_t sdram_cmd_out,
  input wire logic [3:0] rcd_clocks_out, ras_clocks_out, rp_clocks_out,
  input wire logic refresh_enable_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  logic wt, wc;
  logic [2:0] mode_r;
  sdram_cmd_t exp_c;
  sdram_cmd_t cmdx [8] = '{CMD_ACCESS, CMD_NOP, CMD_PRE_ALL, CMD_MODE_SET,
    CMD_REFRESH, CMD_NONE, CMD_NONE, CMD_NONE};
  assign wt = reg_sel_in && reg_wr_in && reg_ofs_in == TIM_OFS;
  assign wc = reg_sel_in && reg_wr_in && reg_ofs_in == CMD_OFS;
  assign exp_c = cmdx[mode_r];
  // shadow of the mode field, only visible through writes
  always_ff @(posedge core_clk_in) begin
    mode_r <= rst_in ? 3'h0 : (wc ? reg_wdata_in[2:0] : mode_r);
  end
  property p_rcd;
    wt |-> ##2 rcd_clocks_out == (($past(reg_wdata_in[3], 2)
      || !$past(reg_wdata_in[2], 2)) ? 4'h2 : 4'h3);
  endproperty
  property p_ras;
    wt |-> ##2 ras_clocks_out == ($past(reg_wdata_in[1], 2) ? 4'ha : 4'h5);
  endproperty
  property p_rp;
    wt |-> ##2 rp_clocks_out == ($past(reg_wdata_in[0], 2) ? 4'h3 : 4'h2);
  endproperty
  property p_rfr;
    wc |-> ##2 refresh_enable_out == ($past(reg_wdata_in[4:3], 2) == 2'h1);
  endproperty
  property p_cmd;
    mem_cycle_in |=> sdram_cmd_out == $past(exp_c);
  endproperty
  property p_idle;
    !mem_cycle_in |=> sdram_cmd_out == CMD_NONE;
  endproperty
  property p_mrs;
    mem_cycle_in && mode_r == 3'h3 |=>
      local_memory_address_lines_out == {5'h00, $past(mem_addr_in[6:0])};
  endproperty
  property p_rd;
    reg_sel_in && !reg_wr_in && reg_ofs_in > CMD_OFS |=> reg_rdata_out == 8'h00;
  endproperty
  a_rcd: assert property (p_rcd) else $error("rcd count");
  a_ras: assert property (p_ras) else $error("ras count");
  a_rp: assert property (p_rp) else $error("rp count");
  a_rfr: assert property (p_rfr) else $error("refresh enable");
  a_cmd: assert property (p_cmd) else $error("forced command");
  a_idle: assert property (p_idle) else $error("idle command");
  a_mrs: assert property (p_mrs) else $error("mode lines");
  a_rd: assert property (p_rd) else $error("unmapped read");
  c_mrs: cover property (mem_cycle_in && mode_r == 3'h3);
  c_ref: cover property (mem_cycle_in && mode_r == 3'h4);
  c_tim: cover property (wt);
endmodule
bind dcache_ctrl dcache_ctrl_chk u_chk (.*);
`default_nettype wire

/* File: sdram_model.sv */
`timescale 1ns/10ps
`default_nettype none
module sdram_model
  import dcache_pkg::*;
(
  input wire logic core_clk_in,
  input wire sdram_cmd_t cmd_in,
  input wire logic [11:0] addr_in,
  output logic [11:0] mode_word_out
);
  // devices latch the whole address word on a mode set
  always @(posedge core_clk_in) begin
    if (cmd_in == CMD_MODE_SET) mode_word_out <= addr_in;
  end
endmodule
`default_nettype wire

/* File: display_cache_sdram_control_test.sv */
`timescale 1ns/10ps
`default_nettype none
module display_cache_sdram_control_test;
  import dcache_pkg::*;
  logic core_clk_in, rst_in, reg_sel_in, reg_wr_in, mem_cycle_in;
  logic [15:0] reg_ofs_in;
  logic [7:0] reg_wdata_in, reg_rdata_out, d, q;
  logic [11:0] mem_addr_in, local_memory_address_lines_out, mw;
  sdram_cmd_t sdram_cmd_out;
  logic memory_fitted_flag_out, page_policy_select_out, refresh_enable_out;
  logic [3:0] rcd_clocks_out, cas_clocks_out, ras_clocks_out, rc_clocks_out, rp_clocks_out;
  logic [31:0] rs = 32'h00011952;
  int n_fail = 0, checks = 0;
  sdram_cmd_t cmdx [8] = '{CMD_ACCESS, CMD_NOP, CMD_PRE_ALL, CMD_MODE_SET,
    CMD_REFRESH, CMD_NONE, CMD_NONE, CMD_NONE};
  dcache_ctrl DUT (.*);
  sdram_model far (.core_clk_in, .cmd_in(sdram_cmd_out),
    .addr_in(local_memory_address_lines_out), .mode_word_out(mw));
  initial begin
    core_clk_in = 1'b0;
    forever #25 core_clk_in = ~core_clk_in;
  end
  function automatic logic [7:0] rnd();
    rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
    return rs[7:0];
  endfunction
  function automatic logic [20:0] tim(input logic [7:0] v);
    return {v[4], ((v[3] || !v[2]) ? 4'h2 : 4'h3), (v[2] ? 4'h3 : 4'h2),
      (v[1] ? 8'haa : 8'h58), (v[0] ? 4'h3 : 4'h2)};
  endfunction
  task automatic chk(input string n, input logic [20:0] e, input logic [20:0] s);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic cyc();
    @(posedge core_clk_in);
    #1;
  endtask
  task automatic acc(input logic w, input logic [15:0] o, input logic [7:0] v);
    reg_sel_in = 1'b1;
    reg_wr_in = w;
    reg_ofs_in = o;
    reg_wdata_in = v;
    cyc();
    // read data stands one cycle only, so take it before the idle edge
    q = reg_rdata_out;
    reg_sel_in = 1'b0;
    cyc();
  endtask
  task automatic rdc(input logic [15:0] o, input logic [7:0] e);
    acc(1'b0, o, 8'h00);
    chk("read", e, q);
  endtask
  task automatic test_done();
    if (n_fail == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #200000;
    n_fail++;
    test_done();
  end
  initial begin
    {rst_in, reg_sel_in, reg_wr_in, mem_cycle_in} = 4'h8;
    {reg_ofs_in, reg_wdata_in, mem_addr_in} = '0;
    repeat (5) cyc();
    rst_in = 1'b0;
    chk("timing", tim(TIM_RST), {page_policy_select_out, rcd_clocks_out,
      cas_clocks_out, ras_clocks_out, rc_clocks_out, rp_clocks_out});
    chk("refresh", 1'b1, refresh_enable_out);
    chk("fitted", 1'b0, memory_fitted_flag_out);
    rdc(POP_OFS, POP_RST);
    rdc(TIM_OFS, TIM_RST);
    rdc(CMD_OFS, CMD_RST);
    acc(1'b1, POP_OFS, 8'hff);
    rdc(POP_OFS, 8'h01);
    chk("fitted", 1'b1, memory_fitted_flag_out);
    for (int i = 0; i < 10; i++) begin
      d = (i == 0) ? 8'hff : ((i == 1) ? 8'h00 : rnd());
      acc(1'b1, TIM_OFS, d);
      rdc(TIM_OFS, d & TIM_MASK);
      chk("timing", tim(d), {page_policy_select_out, rcd_clocks_out,
        cas_clocks_out, ras_clocks_out, rc_clocks_out, rp_clocks_out});
    end
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, CMD_OFS, 8'(i << 3) | 8'he0);
      rdc(CMD_OFS, 8'(i << 3));
      chk("refresh", i == 1, refresh_enable_out);
    end
    // no-operation mode goes first, the bus needs it before others
    for (int j = 0; j < 8; j++) begin
      d = 8'((j == 0) ? 1 : ((j == 1) ? 0 : j));
      acc(1'b1, CMD_OFS, 8'h08 | d);
      mem_addr_in = {4'hf, rnd()};
      mem_cycle_in = 1'b1;
      cyc();
      mem_cycle_in = 1'b0;
      chk("command", cmdx[d[2:0]], sdram_cmd_out);
      if (d == 8'h03) begin
        chk("mode lines", {5'h00, mem_addr_in[6:0]}, local_memory_address_lines_out);
        cyc();
        chk("mode word", {5'h00, mem_addr_in[6:0]}, mw);
      end else begin
        chk("lines", mem_addr_in, local_memory_address_lines_out);
      end
    end
    acc(1'b1, 16'h3003, 8'hff);
    chk("idle", CMD_NONE, sdram_cmd_out);
    rdc(16'h3003, 8'h00);
    rdc(CMD_OFS, 8'h0f);
    acc(1'b1, CMD_OFS, CMD_RST);
    test_done();
  end
endmodule
`default_nettype wire
